//--- ptp_cpu_model.sv
module ptp_cpu_model (
  // Resolved link level
  input  wire logic             line_lv,
  // Reply values, index channel*2+domain
  input  wire logic [7:0][15:0] resp,
  input  wire logic             bad_fcs,
  // Client drive, high pulls the line up
  output logic                  drv
);
  timeunit 1ns;
  timeprecision 1ns;
  int          slot = 0;
  realtime     last = 0;
  logic [39:0] tx;
  logic [23:0] rx;
  logic [15:0] v;

  // Frame check over the two data bytes, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Slot tracker; a long quiet line means a new frame
  initial drv = 1'b0;
  always @(posedge line_lv)
  begin
    if (!drv)
    begin
      if (slot == 64 || $realtime - last > 3000)
        slot = 0;
      last = $realtime;
      if (slot < 40)
      begin
        // Host bit still high at mid slot means a one
        #600 tx = {tx[38:0], line_lv};
        if (slot == 39)
        begin
          v  = resp[{tx[33:32], tx[15:8] == 8'h02}];
          rx = {v, crc8(v) ^ {7'h00, bad_fcs}};
        end
      end
      else
      begin
        // Hold past the host sample, then let the pull-down win
        #200 drv = rx[63 - slot];
        #500 drv = 1'b0;
      end
      slot++;
    end
  end
endmodule

//--- ptp_pkg.sv
package ptp_pkg;

  // Clock and link timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned GAP_TIME_NS   = 14000;
  localparam int unsigned GAP_CYC       = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Idle bit slots per CPU that stretch a single-domain CPU's 64-slot frame to a 67-bit read
  localparam int unsigned PAD_BITS      = 3;

  // Register offsets
  localparam logic [7:0] A_CPU1_RD = 8'h1a;
  localparam logic [7:0] A_CPU2_RD = 8'h1b;
  localparam logic [7:0] A_CPU3_RD = 8'h1c;
  localparam logic [7:0] A_CPU0_RD = 8'h33;
  localparam logic [7:0] A_LOW     = 8'h34;
  localparam logic [7:0] A_HIGH    = 8'h35;
  localparam logic [7:0] A_CFG36   = 8'h36;
  localparam logic [7:0] A_CFG40   = 8'h40;
  localparam logic [7:0] A_ST43    = 8'h43;
  localparam logic [7:0] A_ST81    = 8'h81;
  localparam logic [7:0] A_CFG88   = 8'h88;
  localparam logic [7:0] A_OFF0    = 8'h94;
  localparam logic [7:0] A_OFF1    = 8'h95;
  localparam logic [7:0] A_OFF2    = 8'h96;
  localparam logic [7:0] A_OFF3    = 8'h97;
  // Remote 1 addresses taken over in substitution mode
  localparam logic [7:0] A_R1_RD   = 8'h25;
  localparam logic [7:0] A_R1_LOW  = 8'h4e;
  localparam logic [7:0] A_R1_HIGH = 8'h4f;
  localparam logic [7:0] A_R1_OFF  = 8'h70;
  localparam logic [7:0] A_NONE    = 8'h00;

  // Reset values
  localparam logic [7:0] RST_LOW  = 8'h81;
  localparam logic [7:0] RST_HIGH = 8'h00;

  // Field positions
  localparam int unsigned CFG40_MON_BIT  = 4;
  localparam int unsigned CFG36_SUB_BIT  = 4;
  localparam int unsigned CFG36_DOM0_BIT = 3;
  localparam int unsigned CFG36_SMO_LSB  = 0;
  localparam int unsigned CFG88_NCPU_LSB = 6;
  localparam int unsigned CFG88_DOM1_BIT = 5;
  localparam int unsigned ST43_LIM0_BIT  = 0;
  localparam int unsigned ST43_DERR_BIT  = 1;
  localparam int unsigned ST43_CERR_BIT  = 2;
  localparam int unsigned ST81_LIM_LSB   = 3;

  // Frame contents
  localparam logic [7:0]  CLIENT_BASE = 8'h30;
  localparam logic [7:0]  WR_LEN      = 8'h01;
  localparam logic [7:0]  RD_LEN      = 8'h02;
  localparam logic [7:0]  CMD_DOM0    = 8'h01;
  localparam logic [7:0]  CMD_DOM1    = 8'h02;
  localparam logic [7:0]  CRC_POLY    = 8'h07;
  localparam logic [15:0] ERR_LO      = 16'h8000;
  localparam logic [15:0] ERR_HI      = 16'h8003;
  localparam logic [2:0]  TX_BYTES    = 3'h5;
  localparam int unsigned FRAC_BITS   = 6;

  // Poller states
  typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_DONE, ST_GAP, ST_UPDATE} ptp_state_e;

endpackage

//--- ptp_poller.sv
// Overview of operation
// - Block originates every link transfer, polling each configured CPU in turn.
// - Polling rounds start only while monitoring enable, bit 4 of 0x40, is set; a round under way runs to its end.
// - CPU count minus one sits in bits 7:6 of cpu_count_domains_config.
// - Channels 0-3 use client addresses 0x30-0x33; readings at 0x33,0x1a,0x1b,0x1c.
// - Domain count: channel 0 from 0x36 bit 3; channels 1-3 from cpu_count_domains_config bits 5,4,3.
// - With two domains both are read; only the hotter value is kept.
// - Readings stay in relative negative form, never converted to absolute.
// - All channels share low limit 0x34 (0x81) and high limit 0x35 (0x00).
// - Each channel has a signed offset register 0x94-0x97, one degree per step.
// - Bits 2:0 of 0x36 pick the read count; readings refresh once per interval.
// - Interval is reads times (67 bit times per single-domain CPU, 131 per two-domain CPU, plus 14 us gap).
// - Returned value 0x8000-0x8003 sets data error, bit 1 of 0x43.
// - An error code adds zero to the sum and never reaches a reading.
// - Bad frame check sequence sets communication error, bit 2 of 0x43.
// - Alert output is raised while either error status bit is set.
// - Per-channel limit bits: 0x43 bit 0, cpu_limit_status bits 3-5; they raise alert too.
// - Bit 4 of 0x36 enables substitution mode for the Remote 1 register set.
// - Substitution redirects 0x25->0x33, 0x4e->0x34, 0x4f->0x35 and 0x70->0x94; 0x33, 0x34, 0x35 and 0x94 then read zero.
// - Substitution exchanges Remote 2 and local hysteresis values.
// - Substitution moves Remote 1 fan zones to channel 0 when behaviour is 000.
//
// Added by the designer: the address-and-strobe port.
module ptp_poller #(
  parameter int unsigned BIT_TIME_NS = 1000
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // Register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  // Single-wire link
  input  wire logic            peci_in,
  output logic                 peci_out,
  output logic                 peci_oe,
  // Fan zone behaviour fields of the three outputs
  input  wire logic [2:0]      fan_behav_a,
  input  wire logic [2:0]      fan_behav_b,
  input  wire logic [2:0]      fan_behav_c,
  // Results and routing
  output logic [3:0][7:0]      cpu_temp,
  output logic [2:0]           fan_zone_swap,
  output logic                 hyst_swap,
  output logic                 smb_alert
);

  // Bit slot timing derived from the bit period
  localparam int unsigned BIT_CYC   = BIT_TIME_NS / ptp_pkg::CLK_PERIOD_NS;
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYC / 2 - 1);
  localparam logic [15:0] Q_CYC     = 16'(BIT_CYC / 4);
  localparam logic [15:0] T3_CYC    = 16'(3 * BIT_CYC / 4);
  localparam logic [15:0] GAP_LAST  = 16'(ptp_pkg::GAP_CYC - 1);
  localparam logic [15:0] PAD_CYC   = 16'(ptp_pkg::PAD_BITS * BIT_CYC);

  typedef struct packed {
    ptp_pkg::ptp_state_e st;
    logic [7:0]          lo_lim;
    logic [7:0]          hi_lim;
    logic [7:0]          cfg36;
    logic [7:0]          cfg40;
    logic [7:0]          cfg88;
    logic [3:0][7:0]     offs;
    logic [3:0][7:0]     rdg;
    logic [2:0]          st43;
    logic [2:0]          st81;
    logic [7:0]          rdata;
    logic                sync1;
    logic                sync2;
    logic [15:0]         tmr;
    logic [2:0]          bitn;
    logic [2:0]          bytn;
    logic [7:0]          sh;
    logic [7:0]          crc;
    logic [7:0]          dhi;
    logic [7:0]          dlo;
    logic [1:0]          ch;
    logic                dom;
    logic [7:0]          dom0;
    logic [3:0][20:0]    sum;
    logic [11:0]         rnd;
    logic                pout;
    logic                poe;
    logic                alert;
    logic [2:0]          fzs;
    logic                hsw;
  } ptp_regs_s;

  ptp_regs_s s;
  ptp_regs_s n;

  // Working values of the combinational step
  logic [7:0]         ea;
  logic               rxb;
  logic               two_dom;
  logic               fcs_bad;
  logic               derr;
  logic [15:0]        val16;
  logic [7:0]         tmp8;
  logic [7:0]         hot8;
  logic [3:0]         shv;
  logic [11:0]        rnd_last;
  logic [15:0]        gap_end;
  logic signed [20:0] avg;
  logic [7:0]         res8;

  // Serial CRC-8, most significant bit first
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? ptp_pkg::CRC_POLY : 8'h00);
  endfunction

  // Clamp to the signed 8-bit register range
  function automatic logic [7:0] sat8(input logic signed [20:0] v);
    if (v > $signed(21'h00007f))
      return 8'h7f;
    if (v < $signed(21'h1fff80))
      return 8'h80;
    return v[7:0];
  endfunction

  // Log2 of the read count per smoothing interval
  function automatic logic [3:0] smooth_log2(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h0;
      3'h1:    return 4'h4;
      3'h2:    return 4'h6;
      3'h3:    return 4'h8;
      3'h4:    return 4'h9;
      3'h5:    return 4'ha;
      3'h6:    return 4'hb;
      default: return 4'hc;
    endcase
  endfunction

  // Address seen by the register file, Remote 1 set swapped in when substituting
  function automatic logic [7:0] remap(input logic [7:0] a, input logic sub);
    logic [7:0] r;
    r = a;
    if (sub)
    begin
      case (a)
        ptp_pkg::A_R1_RD:   r = ptp_pkg::A_CPU0_RD;
        ptp_pkg::A_R1_LOW:  r = ptp_pkg::A_LOW;
        ptp_pkg::A_R1_HIGH: r = ptp_pkg::A_HIGH;
        ptp_pkg::A_R1_OFF:  r = ptp_pkg::A_OFF0;
        ptp_pkg::A_CPU0_RD, ptp_pkg::A_LOW, ptp_pkg::A_HIGH, ptp_pkg::A_OFF0:
          r = ptp_pkg::A_NONE;
        default:            r = a;
      endcase
    end
    return r;
  endfunction

  // Open a frame to one CPU, address byte first
  function automatic ptp_regs_s start_xfer(input ptp_regs_s x, input logic [1:0] c,
                                           input logic d);
    ptp_regs_s y;
    y      = x;
    y.st   = ptp_pkg::ST_XFER;
    y.tmr  = 16'h0000;
    y.bitn = 3'h0;
    y.bytn = 3'h0;
    y.ch   = c;
    y.dom  = d;
    y.sh   = ptp_pkg::CLIENT_BASE + {6'h00, c};
    y.crc  = 8'h00;
    return y;
  endfunction

  // Domain count bit of the channel in flight
  always_comb
  begin
    case (s.ch)
      2'h0:    two_dom = s.cfg36[ptp_pkg::CFG36_DOM0_BIT];
      2'h1:    two_dom = s.cfg88[ptp_pkg::CFG88_DOM1_BIT];
      2'h2:    two_dom = s.cfg88[ptp_pkg::CFG88_DOM1_BIT - 1];
      default: two_dom = s.cfg88[ptp_pkg::CFG88_DOM1_BIT - 2];
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    n        = s;
    n.sync1  = peci_in;
    n.sync2  = s.sync1;
    ea       = remap(reg_addr, s.cfg36[ptp_pkg::CFG36_SUB_BIT]);
    rxb      = s.bytn >= ptp_pkg::TX_BYTES;
    val16    = {s.dhi, s.dlo};
    fcs_bad  = s.crc != 8'h00;
    derr     = !fcs_bad && val16 >= ptp_pkg::ERR_LO && val16 <= ptp_pkg::ERR_HI;
    shv      = smooth_log2(s.cfg36[ptp_pkg::CFG36_SMO_LSB +: 3]);
    rnd_last = (12'h001 << shv) - 12'h001;
    // Padding folded into the round gap so each single-domain CPU costs 67 bit times, a two-domain CPU 131
    gap_end  = GAP_LAST + PAD_CYC *
               (16'h0001 + {14'h0000, s.cfg88[ptp_pkg::CFG88_NCPU_LSB +: 2]});
    tmp8     = 8'h00;
    hot8     = 8'h00;
    avg      = '0;
    res8     = 8'h00;

    // Register read, data valid in the next cycle only; status clears on read
    n.rdata = 8'h00;
    if (reg_rd)
    begin
      case (ea)
        ptp_pkg::A_CPU0_RD: n.rdata = s.rdg[0];
        ptp_pkg::A_CPU1_RD: n.rdata = s.rdg[1];
        ptp_pkg::A_CPU2_RD: n.rdata = s.rdg[2];
        ptp_pkg::A_CPU3_RD: n.rdata = s.rdg[3];
        ptp_pkg::A_LOW:     n.rdata = s.lo_lim;
        ptp_pkg::A_HIGH:    n.rdata = s.hi_lim;
        ptp_pkg::A_CFG36:   n.rdata = s.cfg36;
        ptp_pkg::A_CFG40:   n.rdata = s.cfg40;
        ptp_pkg::A_CFG88:   n.rdata = s.cfg88;
        ptp_pkg::A_OFF0:    n.rdata = s.offs[0];
        ptp_pkg::A_OFF1:    n.rdata = s.offs[1];
        ptp_pkg::A_OFF2:    n.rdata = s.offs[2];
        ptp_pkg::A_OFF3:    n.rdata = s.offs[3];
        ptp_pkg::A_ST43:
        begin
          n.rdata = {5'h00, s.st43};
          n.st43  = 3'h0;
        end
        ptp_pkg::A_ST81:
        begin
          n.rdata = {2'h0, s.st81, 3'h0};
          n.st81  = 3'h0;
        end
        default:            n.rdata = 8'h00;
      endcase
    end

    // Register write
    if (reg_wr)
    begin
      case (ea)
        ptp_pkg::A_LOW:   n.lo_lim  = reg_wdata;
        ptp_pkg::A_HIGH:  n.hi_lim  = reg_wdata;
        ptp_pkg::A_CFG36: n.cfg36   = reg_wdata;
        ptp_pkg::A_CFG40: n.cfg40   = reg_wdata;
        ptp_pkg::A_CFG88: n.cfg88   = reg_wdata;
        ptp_pkg::A_OFF0:  n.offs[0] = reg_wdata;
        ptp_pkg::A_OFF1:  n.offs[1] = reg_wdata;
        ptp_pkg::A_OFF2:  n.offs[2] = reg_wdata;
        ptp_pkg::A_OFF3:  n.offs[3] = reg_wdata;
        default:          ;
      endcase
    end

    // Poll engine; status sets come after the read clear so a set wins
    case (s.st)
      ptp_pkg::ST_IDLE:
      begin
        if (s.cfg40[ptp_pkg::CFG40_MON_BIT])
          n = start_xfer(n, 2'h0, 1'b0);
      end
      ptp_pkg::ST_XFER:
      begin
        n.tmr = s.tmr + 16'h0001;
        // Client drives response bits; sample the settled level mid-slot
        if (rxb && s.tmr == HALF_LAST)
        begin
          n.sh  = {s.sh[6:0], s.sync2};
          n.crc = crc_bit(s.crc, s.sync2);
        end
        if (s.tmr == BIT_LAST)
        begin
          n.tmr  = 16'h0000;
          n.bitn = s.bitn + 3'h1;
          if (!rxb)
          begin
            n.crc = crc_bit(s.crc, s.sh[7]);
            n.sh  = {s.sh[6:0], 1'b0};
          end
          if (s.bitn == 3'h7)
          begin
            n.bytn = s.bytn + 3'h1;
            case (s.bytn)
              3'h0: n.sh = ptp_pkg::WR_LEN;
              3'h1: n.sh = ptp_pkg::RD_LEN;
              3'h2: n.sh = s.dom ? ptp_pkg::CMD_DOM1 : ptp_pkg::CMD_DOM0;
              3'h3: n.sh = n.crc;
              3'h4:
              begin
                n.sh  = 8'h00;
                n.crc = 8'h00;
              end
              3'h5: n.dhi = s.sh;
              3'h6: n.dlo = s.sh;
              3'h7: n.st  = ptp_pkg::ST_DONE;
              default: ;
            endcase
          end
        end
      end
      ptp_pkg::ST_DONE:
      begin
        if (fcs_bad)
          n.st43[ptp_pkg::ST43_CERR_BIT] = 1'b1;
        if (derr)
          n.st43[ptp_pkg::ST43_DERR_BIT] = 1'b1;
        // Error codes and broken frames count as zero in the sum
        if (fcs_bad || derr)
          tmp8 = 8'h00;
        else
          tmp8 = sat8($signed({{5{val16[15]}}, val16}) >>> ptp_pkg::FRAC_BITS);
        // Larger signed value is nearer the throttle point
        if (s.dom && $signed(s.dom0) > $signed(tmp8))
          hot8 = s.dom0;
        else
          hot8 = tmp8;
        if (!s.dom && two_dom)
        begin
          n.dom0 = tmp8;
          n      = start_xfer(n, s.ch, 1'b1);
        end
        else
        begin
          n.sum[s.ch] = s.sum[s.ch] + {{13{hot8[7]}}, hot8};
          if (s.ch == s.cfg88[ptp_pkg::CFG88_NCPU_LSB +: 2])
          begin
            n.st  = ptp_pkg::ST_GAP;
            n.tmr = 16'h0000;
          end
          else
            n = start_xfer(n, s.ch + 2'h1, 1'b0);
        end
      end
      ptp_pkg::ST_GAP:
      begin
        // Idle gap plus frame padding closes each polling round
        n.tmr = s.tmr + 16'h0001;
        if (s.tmr == gap_end)
        begin
          if (s.rnd == rnd_last)
            n.st = ptp_pkg::ST_UPDATE;
          else
          begin
            n.rnd = s.rnd + 12'h001;
            n.st  = ptp_pkg::ST_IDLE;
          end
        end
      end
      ptp_pkg::ST_UPDATE:
      begin
        // One refresh per interval; offset applies after averaging
        for (int i = 0; i < 4; i++)
        begin
          if (2'(i) <= s.cfg88[ptp_pkg::CFG88_NCPU_LSB +: 2])
          begin
            avg  = $signed(s.sum[i]) >>> shv;
            res8 = sat8(avg + $signed({{13{s.offs[i][7]}}, s.offs[i]}));
            n.rdg[i] = res8;
            if ($signed(res8) < $signed(s.lo_lim) || $signed(res8) > $signed(s.hi_lim))
            begin
              if (i == 0)
                n.st43[ptp_pkg::ST43_LIM0_BIT] = 1'b1;
              else
                n.st81[i - 1] = 1'b1;
            end
          end
          n.sum[i] = '0;
        end
        n.rnd = 12'h000;
        n.st  = ptp_pkg::ST_IDLE;
      end
      default: n.st = ptp_pkg::ST_IDLE;
    endcase

    // Pin drive: high for a quarter slot on zero, three quarters on one
    n.poe  = 1'b0;
    n.pout = 1'b0;
    if (n.st == ptp_pkg::ST_XFER)
    begin
      if (n.bytn >= ptp_pkg::TX_BYTES)
      begin
        n.poe  = n.tmr < Q_CYC;
        n.pout = n.tmr < Q_CYC;
      end
      else
      begin
        n.poe  = 1'b1;
        n.pout = n.tmr < (n.sh[7] ? T3_CYC : Q_CYC);
      end
    end

    n.alert = (|n.st43) || (|n.st81);
    n.hsw   = n.cfg36[ptp_pkg::CFG36_SUB_BIT];
    n.fzs   = {3{n.hsw}} & {fan_behav_c == 3'h0, fan_behav_b == 3'h0,
                            fan_behav_a == 3'h0};
  end

  // Single state register; reset values are constants only
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s        <= '0;
      s.lo_lim <= ptp_pkg::RST_LOW;
      s.hi_lim <= ptp_pkg::RST_HIGH;
    end
    else
      s <= n;
  end

  // Outputs straight from flops
  assign reg_rdata     = s.rdata;
  assign peci_out      = s.pout;
  assign peci_oe       = s.poe;
  assign cpu_temp      = s.rdg;
  assign fan_zone_swap = s.fzs;
  assign hyst_swap     = s.hsw;
  assign smb_alert     = s.alert;

  // Checks on the engine and status logic
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  chk_idle_quiet: assert property (
    (s.st == ptp_pkg::ST_IDLE && !s.cfg40[ptp_pkg::CFG40_MON_BIT]) |=> !peci_oe)
    else $error("link driven while monitoring disabled");

  chk_addr_byte: assert property (
    (s.st == ptp_pkg::ST_XFER && s.bytn == 3'h0 && s.bitn == 3'h0 && s.tmr == 16'h0000)
    |-> s.sh == ptp_pkg::CLIENT_BASE + {6'h00, s.ch})
    else $error("wrong client address");

  chk_tx_pulse: assert property (
    (s.st == ptp_pkg::ST_XFER && s.bytn < ptp_pkg::TX_BYTES && s.tmr == 16'h0000)
    |-> peci_oe && peci_out)
    else $error("bit slot does not open high");

  chk_data_err: assert property (
    (s.st == ptp_pkg::ST_DONE && derr) |=> s.st43[ptp_pkg::ST43_DERR_BIT] && smb_alert)
    else $error("data error not flagged");

  chk_comm_err: assert property (
    (s.st == ptp_pkg::ST_DONE && fcs_bad) |=> s.st43[ptp_pkg::ST43_CERR_BIT])
    else $error("communication error not flagged");

  chk_alert_err: assert property (
    (s.st43 != 3'h0 || s.st81 != 3'h0) |-> smb_alert)
    else $error("alert missing with status set");

  chk_gap_hold: assert property (
    $rose(s.st == ptp_pkg::ST_GAP) |-> (s.st == ptp_pkg::ST_GAP)[*8])
    else $error("gap cut short");

  chk_update_once: assert property (
    (s.st == ptp_pkg::ST_UPDATE) |-> $past(s.st) == ptp_pkg::ST_GAP && s.rnd == rnd_last
    ##1 s.sum == '0 && s.rnd == 12'h000)
    else $error("refresh outside interval end");

  chk_err_zero: assert property (
    (s.st == ptp_pkg::ST_DONE && (derr || fcs_bad) && !s.dom && !two_dom)
    |=> s.sum[$past(s.ch)] == $past(s.sum[s.ch]))
    else $error("error code entered the sum");

  cov_two_dom: cover property (s.st == ptp_pkg::ST_DONE && s.dom);
  cov_update: cover property (s.st == ptp_pkg::ST_UPDATE);
  cov_comm_err: cover property (s.st == ptp_pkg::ST_DONE && fcs_bad);
  cov_sub_mode: cover property (hyst_swap && fan_zone_swap != 3'h0);

endmodule

//--- test_ptp_poller.sv
module test_ptp_poller;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_sys     = 1'b0;
  logic             nrst        = 1'b0;
  logic [7:0]       reg_addr    = 8'h00;
  logic [7:0]       reg_wdata   = 8'h00;
  logic             reg_wr      = 1'b0;
  logic             reg_rd      = 1'b0;
  logic [2:0]       fan_behav_a = 3'h0;
  logic [2:0]       fan_behav_b = 3'h1;
  logic [2:0]       fan_behav_c = 3'h0;
  logic [7:0][15:0] resp        = {8{16'hfd80}};
  logic             bad_fcs     = 1'b0;
  logic [7:0]       reg_rdata;
  logic             peci_out;
  logic             peci_oe;
  logic             cli_drv;
  logic [3:0][7:0]  cpu_temp;
  logic [2:0]       fan_zone_swap;
  logic             hyst_swap;
  logic             smb_alert;
  int               failures    = 0;
  int               n_tests     = 0;
  // Released line falls to the pull-down unless a client drives it
  wire logic        peci_in     = peci_oe ? peci_out : cli_drv;

  ptp_poller ptp_poller_i (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .peci_in(peci_in), .peci_out(peci_out), .peci_oe(peci_oe),
    .fan_behav_a(fan_behav_a), .fan_behav_b(fan_behav_b), .fan_behav_c(fan_behav_c),
    .cpu_temp(cpu_temp), .fan_zone_swap(fan_zone_swap), .hyst_swap(hyst_swap),
    .smb_alert(smb_alert));

  ptp_cpu_model ptp_cpu_model_i (.line_lv(peci_in), .resp(resp), .bad_fcs(bad_fcs),
    .drv(cli_drv));

  always #10 clk_sys = ~clk_sys;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    cmp(reg_rdata, exp);
  endtask

  // Monitoring on for frames*3201+900 cycles, then off with a drain so the round in flight ends
  task automatic run(input int frames);
    wr(8'h40, 8'h10);
    repeat (frames * 3201 + 900) @(posedge clk_sys);
    wr(8'h40, 8'h00);
    repeat (frames * 3201 + 900) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    int hi = 0;
    chk(8'h34, 8'h81);
    chk(8'h35, 8'h00);
    wr(8'h43, 8'h07);
    chk(8'h43, 8'h00);
    chk(8'h50, 8'h00);
    repeat (300)
    begin
      @(posedge clk_sys);
      if (peci_oe !== 1'b0)
        hi++;
    end
    cmp(8'(hi), 8'h00);
  endtask

  task automatic t_one;
    wr(8'h94, 8'h03);
    run(1);
    chk(8'h33, 8'hf9);
    cmp(cpu_temp[0], 8'hf9);
  endtask

  // Four CPUs, channel 1 with two domains, mixed limit results
  task automatic t_multi;
    resp[2] <= 16'hfb00;
    resp[3] <= 16'hfec0;
    resp[4] <= 16'hf880;
    resp[5] <= 16'hffc0;
    resp[6] <= 16'hf600;
    wr(8'h97, 8'h05);
    wr(8'h35, 8'hf0);
    wr(8'h88, 8'he0);
    run(5);
    chk(8'h1a, 8'hfb);
    chk(8'h1b, 8'he2);
    chk(8'h1c, 8'hdd);
    cmp(cpu_temp[1], 8'hfb);
    cmp(cpu_temp[2], 8'he2);
    cmp(cpu_temp[3], 8'hdd);
    cmp({7'h0, smb_alert}, 8'h01);
    chk(8'h43, 8'h01);
    chk(8'h81, 8'h08);
    chk(8'h43, 8'h00);
    cmp({7'h0, smb_alert}, 8'h00);
  endtask

  task automatic t_subst;
    wr(8'h36, 8'h10);
    chk(8'h25, 8'hf9);
    chk(8'h33, 8'h00);
    wr(8'h4f, 8'h12);
    chk(8'h4f, 8'h12);
    cmp({4'h0, hyst_swap, fan_zone_swap}, 8'h0d);
    wr(8'h36, 8'h00);
    chk(8'h35, 8'h12);
    wr(8'h35, 8'h00);
  endtask

  // Error replies add zero, so the reading is the zero offset
  task automatic t_err(input logic [15:0] code, input logic bad, input logic [7:0] st);
    resp[0] <= code;
    bad_fcs <= bad;
    wr(8'h88, 8'h00);
    wr(8'h94, 8'h00);
    run(1);
    cmp({7'h0, smb_alert}, 8'h01);
    chk(8'h43, st);
    chk(8'h33, 8'h00);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog sized above the sum of all polling passes
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    summarize;
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_one;
    t_multi;
    t_subst;
    t_err(16'h8000, 1'b0, 8'h02);
    t_err(16'h8003, 1'b0, 8'h02);
    t_err(16'hfd80, 1'b1, 8'h04);
    summarize;
  end
endmodule
